//--- core/isa_autoconfig_state_machine.sv
`timescale 1ns/1ps

module isa_autoconfig_state_machine #(
  parameter logic [63:0] SERIAL_ID = 64'h0123_4567_89ab_cdef  // arbitrary identifier value
) (
  input  wire logic        core_clk,
  input  wire logic        srst,
  input  wire logic [11:0] isa_sa,
  input  wire logic [7:0]  isa_sd_in,
  input  wire logic        isa_iow_n,
  input  wire logic        isa_ior_n,
  output logic      [7:0]  isa_sd_out,
  output logic             isa_sd_oe,
  output logic      [1:0]  pnp_state,
  output logic      [7:0]  card_handle,
  output logic             card_activate
);

  //////////////////////////////////////////////////////////////////////////////
  // declarations
  isa_autoconfig_pkg::isa_pins_s  pins_in;
  isa_autoconfig_pkg::isa_pins_s  s1_r;
  isa_autoconfig_pkg::isa_pins_s  s2_r;
  isa_autoconfig_pkg::isa_pins_s  s3_r;
  isa_autoconfig_pkg::isa_pins_s  filt_r;
  isa_autoconfig_pkg::isa_pins_s  filt_nxt;
  isa_autoconfig_pkg::isa_pins_s  prev_r;
  isa_autoconfig_pkg::pnp_state_e state_r;
  isa_autoconfig_pkg::pnp_state_e state_nxt;

  logic [7:0] index_r;
  logic [7:0] handle_r;
  logic [7:0] handle_nxt;
  logic       activate_r;
  logic [7:0] rd_port_r;
  logic [7:0] key_lfsr_r;
  logic [5:0] key_cnt_r;
  logic [6:0] iso_bit_r;
  logic       iso_second_r;
  logic       iso_done_r;
  logic [7:0] chk_r;
  logic [7:0] rd_bus_r;
  logic       rd_active_r;
  logic       rd_serial_r;
  logic [7:0] sd_out_r;
  logic       sd_oe_r;

  logic       wr_start;
  logic       rd_start;
  logic       rd_end;
  logic       wr_addr;
  logic       wr_data;
  logic       rd_hit;
  logic [7:0] key_next;
  logic       cur_bit;
  logic       lost;
  logic [7:0] rd_value;

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: three stages, change counted when stages two and three agree
  assign pins_in = '{sa: isa_sa, sd: isa_sd_in, iow_n: isa_iow_n, ior_n: isa_ior_n};

  // three-stage capture of every pin, no reset needed on the raw stages
  always_ff @(posedge core_clk) begin
    s1_r <= pins_in;
    s2_r <= s1_r;
    s3_r <= s2_r;
  end

  // a bit follows the pins only once stages two and three agree
  genvar g;
  generate
    for (g = 0; g < $bits(isa_autoconfig_pkg::isa_pins_s); g++) begin : g_filt
      assign filt_nxt[g] = (s2_r[g] == s3_r[g]) ? s3_r[g] : filt_r[g];
    end
  endgenerate

  // filtered level and a copy one cycle older; idle strobes avoid a false edge after reset
  always_ff @(posedge core_clk) begin
    if (srst) begin
      filt_r <= '{sa: 12'h000, sd: 8'h00, iow_n: 1'b1, ior_n: 1'b1};
      prev_r <= '{sa: 12'h000, sd: 8'h00, iow_n: 1'b1, ior_n: 1'b1};
    end else begin
      filt_r <= filt_nxt;
      prev_r <= filt_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // strobe edges and port decode
  assign wr_start = prev_r.iow_n & ~filt_r.iow_n;
  assign rd_start = prev_r.ior_n & ~filt_r.ior_n;
  assign rd_end   = ~prev_r.ior_n & filt_r.ior_n;
  assign wr_addr  = wr_start && (filt_r.sa == isa_autoconfig_pkg::ADDR_PORT);
  assign wr_data  = wr_start && (filt_r.sa == isa_autoconfig_pkg::WDATA_PORT) &&
                    (state_r != isa_autoconfig_pkg::ST_KEY_WAIT);
  assign rd_hit   = rd_start && rd_port_r[isa_autoconfig_pkg::RD_PORT_OK_BIT] &&
                    (filt_r.sa == {2'h0, rd_port_r, isa_autoconfig_pkg::RD_PORT_LOW}) &&
                    (state_r != isa_autoconfig_pkg::ST_KEY_WAIT) &&
                    (state_r != isa_autoconfig_pkg::ST_SLEEP);

  //////////////////////////////////////////////////////////////////////////////
  // initiation key matcher, runs only in key-wait
  assign key_next = {key_lfsr_r[1] ^ key_lfsr_r[0], key_lfsr_r[7:1]};

  // matcher advances on each correct byte; a seed byte restarts it at one
  always_ff @(posedge core_clk) begin
    if (srst || state_r != isa_autoconfig_pkg::ST_KEY_WAIT) begin
      key_lfsr_r <= isa_autoconfig_pkg::KEY_SEED;
      key_cnt_r  <= 6'd0;
    end else if (wr_addr) begin
      if (filt_r.sd == key_lfsr_r) begin
        key_lfsr_r <= key_next;
        key_cnt_r  <= key_cnt_r + 6'd1;
      end else if (filt_r.sd == isa_autoconfig_pkg::KEY_SEED) begin
        key_lfsr_r <= {isa_autoconfig_pkg::KEY_SEED[1] ^ isa_autoconfig_pkg::KEY_SEED[0],
                       isa_autoconfig_pkg::KEY_SEED[7:1]};
        key_cnt_r  <= 6'd1;
      end else begin
        key_lfsr_r <= isa_autoconfig_pkg::KEY_SEED;
        key_cnt_r  <= 6'd0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // index register, kept until the next address-port write outside key-wait
  always_ff @(posedge core_clk) begin
    if (srst) begin
      index_r <= isa_autoconfig_pkg::IDX_RST;
    end else if (wr_addr && state_r != isa_autoconfig_pkg::ST_KEY_WAIT) begin
      index_r <= filt_r.sd;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // isolation: serial bit pick and loss detection
  assign cur_bit = (iso_bit_r < isa_autoconfig_pkg::ID_BITS) ?
                   SERIAL_ID[iso_bit_r[5:0]] : chk_r[iso_bit_r[2:0]];
  // a floating card that saw the driven pattern on the bus has lost
  assign lost    = rd_end && rd_serial_r && !cur_bit &&
                   (rd_bus_r == (iso_second_r ? isa_autoconfig_pkg::ISO_SECOND
                                              : isa_autoconfig_pkg::ISO_FIRST));

  // bit counter, pair phase and checksum over the identifier
  always_ff @(posedge core_clk) begin
    if (srst || state_r != isa_autoconfig_pkg::ST_ISOLATE) begin
      iso_bit_r    <= 7'd0;
      iso_second_r <= 1'b0;
      iso_done_r   <= 1'b0;
      chk_r        <= isa_autoconfig_pkg::CHK_SEED;
    end else if (rd_end && rd_serial_r) begin
      iso_second_r <= ~iso_second_r;
      if (iso_second_r) begin
        if (iso_bit_r == isa_autoconfig_pkg::ISO_PAIRS - 7'd1) begin
          iso_done_r <= 1'b1;
        end else begin
          iso_bit_r <= iso_bit_r + 7'd1;
        end
        if (iso_bit_r < isa_autoconfig_pkg::ID_BITS) begin
          chk_r <= {chk_r[1] ^ chk_r[0] ^ cur_bit, chk_r[7:1]};
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read cycle tracking; bus level captured while the read strobe is low
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rd_active_r <= 1'b0;
      rd_serial_r <= 1'b0;
      rd_bus_r    <= 8'h00;
    end else begin
      if (rd_hit) begin
        rd_active_r <= 1'b1;
        rd_serial_r <= (index_r == isa_autoconfig_pkg::IDX_SERIAL) &&
                       (state_r == isa_autoconfig_pkg::ST_ISOLATE) && !iso_done_r;
      end else if (rd_end) begin
        rd_active_r <= 1'b0;
        rd_serial_r <= 1'b0;
      end
      if (!filt_r.ior_n) begin
        rd_bus_r <= filt_r.sd;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // readback data selection by the held index
  always_comb begin
    rd_value = isa_autoconfig_pkg::RD_IDLE;
    if (state_r == isa_autoconfig_pkg::ST_ISOLATE) begin
      if (index_r == isa_autoconfig_pkg::IDX_SERIAL && !iso_done_r && cur_bit) begin
        rd_value = iso_second_r ? isa_autoconfig_pkg::ISO_SECOND
                                : isa_autoconfig_pkg::ISO_FIRST;
      end
    end else if (state_r == isa_autoconfig_pkg::ST_CONFIG) begin
      unique case (index_r)
        isa_autoconfig_pkg::IDX_HANDLE:    rd_value = handle_r;
        isa_autoconfig_pkg::IDX_PNP_STATE: rd_value = {6'h00, state_r};
        isa_autoconfig_pkg::IDX_ACTIVATE:  rd_value = {7'h00, activate_r};
        default:                           rd_value = isa_autoconfig_pkg::RD_IDLE;
      endcase
    end
  end

  // drive the bus only for a decoded read; serial bit zero leaves the bus floating
  always_ff @(posedge core_clk) begin
    if (srst) begin
      sd_oe_r  <= 1'b0;
      sd_out_r <= 8'h00;
    end else if (rd_hit) begin
      sd_out_r <= rd_value;
      sd_oe_r  <= !((index_r == isa_autoconfig_pkg::IDX_SERIAL) &&
                    (state_r == isa_autoconfig_pkg::ST_ISOLATE) && !cur_bit);
    end else if (rd_end || !rd_active_r) begin
      sd_oe_r <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // readback port location, written only in isolation
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rd_port_r <= isa_autoconfig_pkg::RD_PORT_RST;
    end else if (wr_data && index_r == isa_autoconfig_pkg::IDX_SET_RD &&
                 state_r == isa_autoconfig_pkg::ST_ISOLATE) begin
      rd_port_r <= filt_r.sd;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // activate bit, written in configuration state only; the control reset bit clears it in any state but key-wait
  always_ff @(posedge core_clk) begin
    if (srst) begin
      activate_r <= isa_autoconfig_pkg::ACT_RST;
    end else if (wr_data && index_r == isa_autoconfig_pkg::IDX_CFG_CTRL &&
                 filt_r.sd[isa_autoconfig_pkg::CTRL_RESET_BIT]) begin
      activate_r <= isa_autoconfig_pkg::ACT_RST;
    end else if (wr_data && index_r == isa_autoconfig_pkg::IDX_ACTIVATE &&
                 state_r == isa_autoconfig_pkg::ST_CONFIG) begin
      activate_r <= filt_r.sd[isa_autoconfig_pkg::ACT_BIT];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // next state and handle
  always_comb begin
    state_nxt  = state_r;
    handle_nxt = handle_r;
    unique case (state_r)
      isa_autoconfig_pkg::ST_KEY_WAIT: begin
        if (wr_addr && filt_r.sd == key_lfsr_r &&
            key_cnt_r == isa_autoconfig_pkg::KEY_LEN - 6'd1) begin
          state_nxt = isa_autoconfig_pkg::ST_SLEEP;
        end
      end
      isa_autoconfig_pkg::ST_SLEEP: begin
        if (wr_data && index_r == isa_autoconfig_pkg::IDX_WAKE && filt_r.sd == handle_r) begin
          if (filt_r.sd == 8'h00) begin
            state_nxt = isa_autoconfig_pkg::ST_ISOLATE;
          end else begin
            state_nxt = isa_autoconfig_pkg::ST_CONFIG;
          end
        end
      end
      isa_autoconfig_pkg::ST_ISOLATE: begin
        if (lost) begin
          state_nxt = isa_autoconfig_pkg::ST_SLEEP;
        end else if (wr_data && index_r == isa_autoconfig_pkg::IDX_WAKE) begin
          state_nxt = isa_autoconfig_pkg::ST_SLEEP;
        end else if (wr_data && index_r == isa_autoconfig_pkg::IDX_HANDLE) begin
          handle_nxt = filt_r.sd;
          state_nxt  = isa_autoconfig_pkg::ST_CONFIG;
        end
      end
      isa_autoconfig_pkg::ST_CONFIG: begin
        if (wr_data && index_r == isa_autoconfig_pkg::IDX_WAKE &&
            (filt_r.sd == 8'h00 || filt_r.sd != handle_r)) begin
          state_nxt = isa_autoconfig_pkg::ST_SLEEP;
        end
      end
    endcase
    // configuration control applies in every state but key-wait
    if (wr_data && index_r == isa_autoconfig_pkg::IDX_CFG_CTRL) begin
      if (filt_r.sd[isa_autoconfig_pkg::CTRL_CLR_HANDLE_BIT]) begin
        handle_nxt = isa_autoconfig_pkg::HANDLE_RST;
      end
      if (filt_r.sd[isa_autoconfig_pkg::CTRL_WFK_BIT]) begin
        state_nxt = isa_autoconfig_pkg::ST_KEY_WAIT;
      end
    end
  end

  // state and handle registers
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_r  <= isa_autoconfig_pkg::ST_KEY_WAIT;
      handle_r <= isa_autoconfig_pkg::HANDLE_RST;
    end else begin
      state_r  <= state_nxt;
      handle_r <= handle_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs, all from flip-flops
  assign isa_sd_out    = sd_out_r;
  assign isa_sd_oe     = sd_oe_r;
  assign pnp_state     = state_r;
  assign card_handle   = handle_r;
  assign card_activate = activate_r;

endmodule : isa_autoconfig_state_machine

//--- shared/isa_autoconfig_pkg.sv
package isa_autoconfig_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // fixed port decode, 12-bit isa address
  localparam logic [11:0] ADDR_PORT      = 12'h279;
  localparam logic [11:0] WDATA_PORT     = 12'ha79;
  localparam logic [1:0]  RD_PORT_LOW    = 2'h3;    // low address bits of the readback port
  localparam int          RD_PORT_OK_BIT = 7;       // set keeps the port inside 0x203..0x3ff
  localparam logic [7:0]  RD_PORT_RST    = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // register indices
  localparam logic [7:0] IDX_SET_RD    = 8'h00;
  localparam logic [7:0] IDX_SERIAL    = 8'h01;
  localparam logic [7:0] IDX_CFG_CTRL  = 8'h02;
  localparam logic [7:0] IDX_WAKE      = 8'h03;
  localparam logic [7:0] IDX_HANDLE    = 8'h06;
  localparam logic [7:0] IDX_PNP_STATE = 8'h25;
  localparam logic [7:0] IDX_ACTIVATE  = 8'h30;
  localparam logic [7:0] IDX_RST       = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // field positions and reset values
  localparam int         CTRL_RESET_BIT = 0;       // restore power-up configuration
  localparam int         CTRL_WFK_BIT   = 1;       // return to key-wait
  localparam int         CTRL_CLR_HANDLE_BIT = 2;  // clear card handle
  localparam int         ACT_BIT        = 0;
  localparam logic [7:0] HANDLE_RST     = 8'h00;
  localparam logic       ACT_RST        = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // initiation key and isolation protocol
  localparam logic [7:0] KEY_SEED   = 8'h6a;
  localparam logic [5:0] KEY_LEN    = 6'd32;
  localparam logic [7:0] CHK_SEED   = 8'h6a;
  localparam logic [6:0] ISO_PAIRS  = 7'd72;
  localparam logic [6:0] ID_BITS    = 7'd64;
  localparam logic [7:0] ISO_FIRST  = 8'h55;
  localparam logic [7:0] ISO_SECOND = 8'haa;
  localparam logic [7:0] RD_IDLE    = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [1:0] {
    ST_KEY_WAIT = 2'b00,
    ST_SLEEP    = 2'b01,
    ST_ISOLATE  = 2'b10,
    ST_CONFIG   = 2'b11
  } pnp_state_e;

  typedef struct packed {
    logic [11:0] sa;
    logic [7:0]  sd;
    logic        iow_n;
    logic        ior_n;
  } isa_pins_s;

endpackage : isa_autoconfig_pkg

//--- testbench/isa_autoconfig_asserts.sv
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////
// port checks; states: 0 key-wait, 1 sleep, 2 isolation, 3 configuration
module isa_autoconfig_asserts (
  input wire logic        core_clk,
  input wire logic        srst,
  input wire logic [11:0] isa_sa,
  input wire logic        isa_ior_n,
  input wire logic        isa_sd_oe,
  input wire logic [1:0]  pnp_state,
  input wire logic [7:0]  card_handle,
  input wire logic        card_activate
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  // reset lands on the next edge, so this one is not disabled by reset
  AST_RESET_STATE:
    assert property (disable iff (1'h0) srst |=> pnp_state == 2'h0 && card_handle == 8'h00 && !card_activate)
    else $error("reset left state, handle or activate set");
  AST_KEYWAIT_QUIET:
    assert property (pnp_state == 2'h0 |-> !isa_sd_oe) else $error("card drove the bus in key-wait");
  AST_KEYWAIT_HOLD:
    assert property ($past(pnp_state) == 2'h0 && pnp_state == 2'h0 |-> $stable(card_handle) && $stable(card_activate))
    else $error("command acted in key-wait");
  AST_KEY_TO_SLEEP:
    assert property ($past(pnp_state) == 2'h0 && pnp_state != 2'h0 |-> pnp_state == 2'h1)
    else $error("key-wait left for a state other than sleep");
  AST_SLEEP_TO_ISO:
    assert property ($past(pnp_state) == 2'h1 && pnp_state == 2'h2 |-> $past(card_handle) == 8'h00)
    else $error("card with a handle entered isolation");
  AST_SLEEP_TO_CFG:
    assert property ($past(pnp_state) == 2'h1 && pnp_state == 2'h3 |-> $past(card_handle) != 8'h00)
    else $error("card without a handle entered configuration");
  // the card answers only a read strobe at a legal readback address
  AST_READ_WINDOW:
    assert property ($rose(isa_sd_oe) |-> isa_sa[11:9] == 3'h1 && isa_sa[1:0] == 2'h3 && $past(isa_ior_n, 3) == 1'h0)
    else $error("bus driven outside a readback cycle");
  AST_READ_RELEASE:
    assert property ($rose(isa_ior_n) |-> ##[1:8] !isa_sd_oe) else $error("bus not released after read");

  cover property (pnp_state == 2'h3);
  cover property ($past(pnp_state) == 2'h2 && pnp_state == 2'h1);
  cover property ($rose(isa_sd_oe));
endmodule : isa_autoconfig_asserts

bind isa_autoconfig_state_machine isa_autoconfig_asserts chk_u (.core_clk(core_clk), .srst(srst), .isa_sa(isa_sa),
  .isa_ior_n(isa_ior_n), .isa_sd_oe(isa_sd_oe), .pnp_state(pnp_state), .card_handle(card_handle),
  .card_activate(card_activate));

//--- testbench/isa_host_model.sv
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////
// host configuration software issuing isa i/o cycles
module isa_host_model (
  input  wire logic                     core_clk,
  input  wire logic [7:0]               card_sd,
  input  wire logic                     card_oe,
  output isa_autoconfig_pkg::isa_pins_s pins,
  output logic      [7:0]               bus_lvl
);
  logic       drv_en;    // host drives the data lines in a write
  logic       rival;     // a second card answers every serial read
  logic       rd_first;  // rival answer alternates between pair halves
  logic [3:0] cyc;

  initial begin
    pins     = '{sa: 12'h000, sd: 8'h00, iow_n: 1'h1, ior_n: 1'h1};
    drv_en   = 1'h0;
    rival    = 1'h0;
    rd_first = 1'h1;
    cyc      = 4'h0;
  end

  // free-running count for the released bus pattern
  always @(posedge core_clk) cyc <= cyc + 4'h1;

  // bus level; a released bus changes every cycle and never looks like isolation data
  always_comb begin
    if (drv_en) bus_lvl = pins.sd;
    else if (card_oe) bus_lvl = card_sd;
    else if (rival && !pins.ior_n) bus_lvl = rd_first ? isa_autoconfig_pkg::ISO_FIRST : isa_autoconfig_pkg::ISO_SECOND;
    else bus_lvl = {cyc, ~cyc};
  end

  // write cycle: address and data settle before the strobe and stay through its rise
  task automatic io_write(input logic [11:0] a, input logic [7:0] d);
    @(negedge core_clk);
    pins.sa = a;
    pins.sd = d;
    drv_en  = 1'h1;
    repeat (8) @(negedge core_clk);
    pins.iow_n = 1'h0;
    repeat (10) @(negedge core_clk);
    pins.iow_n = 1'h1;
    repeat (9) @(negedge core_clk);
    drv_en = 1'h0;
  endtask : io_write

  // read cycle: sample the bus while the strobe is still low
  task automatic io_read(input logic [11:0] a, output logic oe, output logic [7:0] d);
    @(negedge core_clk);
    pins.sa = a;
    repeat (8) @(negedge core_clk);
    pins.ior_n = 1'h0;
    repeat (9) @(negedge core_clk);
    oe         = card_oe;
    d          = bus_lvl;
    pins.ior_n = 1'h1;
    rd_first   = ~rd_first;
    repeat (9) @(negedge core_clk);
  endtask : io_read
endmodule : isa_host_model

//--- testbench/tb.sv
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////
// bench: host model drives the card, a bench model predicts it
module tb;
  localparam logic [63:0] SER_ID = 64'h5a3c_96e1_0f87_d2b4;  // arbitrary identifier value
  localparam int          TMO    = 40000;                   // run needs about 9900 cycles

  logic                          core_clk = 1'h0;
  logic                          srst = 1'h1;
  isa_autoconfig_pkg::isa_pins_s pins;
  logic [7:0]                    bus_lvl;
  logic [7:0]                    isa_sd_out;
  logic                          isa_sd_oe;
  logic [1:0]                    pnp_state;
  logic [7:0]                    card_handle;
  logic                          card_activate;
  int                            num_errors = 0;
  int                            n_checks = 0;
  int                            cycles = 0;
  logic [31:0]                   rnd = 32'h640f56e4;
  logic [1:0]                    m_state = 2'h0;
  logic [7:0]                    m_handle = 8'h00;
  logic                          m_act = 1'h0;
  logic [11:0]                   rdp = 12'h203;
  logic [7:0]                    h;
  logic                          b_q[$];

  isa_host_model host_u (.core_clk(core_clk), .card_sd(isa_sd_out), .card_oe(isa_sd_oe), .pins(pins), .bus_lvl(bus_lvl));
  isa_autoconfig_state_machine #(.SERIAL_ID(SER_ID)) dut_u (.core_clk(core_clk), .srst(srst), .isa_sa(pins.sa),
    .isa_sd_in(bus_lvl), .isa_iow_n(pins.iow_n), .isa_ior_n(pins.ior_n), .isa_sd_out(isa_sd_out),
    .isa_sd_oe(isa_sd_oe), .pnp_state(pnp_state), .card_handle(card_handle), .card_activate(card_activate));

  // clock and hang guard
  always #10 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == TMO) begin
      num_errors++;
      $display("BAD cycle limit expected %0d seen %0d", TMO - 1, cycles);
      end_of_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs

  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk8

  task automatic chk_model(input string what);
    chk8({what, " state"}, {6'h00, m_state}, {6'h00, pnp_state});
    chk8({what, " handle"}, m_handle, card_handle);
    chk8({what, " activate"}, {7'h00, m_act}, {7'h00, card_activate});
  endtask : chk_model

  // index write, data write, then the bench model steps and is compared
  task automatic cmd(input logic [7:0] idx, input logic [7:0] d, input string what);
    host_u.io_write(isa_autoconfig_pkg::ADDR_PORT, idx);
    host_u.io_write(isa_autoconfig_pkg::WDATA_PORT, d);
    if (m_state != 2'h0 && idx == isa_autoconfig_pkg::IDX_WAKE) begin
      if (m_state == 2'h1 && d == m_handle) m_state = (d == 8'h00) ? 2'h2 : 2'h3;
      else if (m_state != 2'h1 && !(m_state == 2'h3 && d == m_handle && d != 8'h00)) m_state = 2'h1;
    end
    if (m_state != 2'h0 && idx == isa_autoconfig_pkg::IDX_CFG_CTRL) begin
      m_act    = d[0] ? 1'h0 : m_act;
      m_handle = d[2] ? 8'h00 : m_handle;
      m_state  = d[1] ? 2'h0 : m_state;
    end
    if (m_state == 2'h2 && idx == isa_autoconfig_pkg::IDX_HANDLE) begin
      m_handle = d;
      m_state  = 2'h3;
    end
    if (m_state == 2'h3 && idx == isa_autoconfig_pkg::IDX_ACTIVATE) m_act = d[0];
    chk_model(what);
  endtask : cmd

  task automatic rd_chk(input logic set_idx, input logic [7:0] idx, input logic exp_oe, input logic [7:0] exp);
    logic       oe;
    logic [7:0] d;
    if (set_idx) host_u.io_write(isa_autoconfig_pkg::ADDR_PORT, idx);
    host_u.io_read(rdp, oe, d);
    chk8("read drive", {7'h00, exp_oe}, {7'h00, oe});
    if (exp_oe) chk8("read data", exp, d);
  endtask : rd_chk

  // key bytes; a negative position sends the whole key unbroken
  task automatic send_key(input int bad_at);
    logic [7:0] k;
    k = isa_autoconfig_pkg::KEY_SEED;
    for (int i = 0; i < int'(isa_autoconfig_pkg::KEY_LEN); i++) begin
      host_u.io_write(isa_autoconfig_pkg::ADDR_PORT, (i == bad_at) ? ~k : k);
      k = {k[1] ^ k[0], k[7:1]};
    end
    m_state = (bad_at < 0 && m_state == 2'h0) ? 2'h1 : m_state;
  endtask : send_key

  // serial isolation pairs: identifier lsb first, then the running checksum
  task automatic iso_reads(input int pairs);
    logic [7:0] c;
    logic       b;
    c   = isa_autoconfig_pkg::CHK_SEED;
    b_q = {};
    for (int i = 0; i < int'(isa_autoconfig_pkg::ID_BITS); i++) begin
      b_q.push_back(SER_ID[i]);
      c = {c[1] ^ c[0] ^ SER_ID[i], c[7:1]};
    end
    for (int i = 0; i < 8; i++) b_q.push_back(c[i]);
    host_u.rd_first = 1'h1;
    host_u.io_write(isa_autoconfig_pkg::ADDR_PORT, isa_autoconfig_pkg::IDX_SERIAL);
    for (int i = 0; i < pairs; i++) begin
      b = b_q.pop_front();
      rd_chk(1'h0, 8'h00, b, isa_autoconfig_pkg::ISO_FIRST);
      rd_chk(1'h0, 8'h00, b, isa_autoconfig_pkg::ISO_SECOND);
    end
  endtask : iso_reads

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_of_test

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (10) @(negedge core_clk);
    srst = 1'h0;
    chk_model("reset");
    rnd = xs(rnd);
    cmd(isa_autoconfig_pkg::IDX_WAKE, 8'h00, "key-wait wake");
    cmd(rnd[7:0], rnd[15:8], "key-wait stray");
    rd_chk(1'h1, isa_autoconfig_pkg::IDX_HANDLE, 1'h0, 8'h00);
    send_key(10);
    chk_model("broken key");
    send_key(-1);
    chk_model("key");
    send_key(-1);
    chk_model("key again");
    $display("test key done");
    cmd(isa_autoconfig_pkg::IDX_WAKE, {rnd[23:17] | 7'h01, 1'h0}, "foreign wake");
    cmd(isa_autoconfig_pkg::IDX_WAKE, 8'h00, "wake zero");
    rdp = {3'h1, rnd[30:24], 2'h3};
    cmd(isa_autoconfig_pkg::IDX_SET_RD, rdp[9:2], "readback port");
    iso_reads(int'(isa_autoconfig_pkg::ISO_PAIRS));
    chk_model("isolated");
    rnd = xs(rnd);
    h = (rnd[7:0] == 8'h00) ? 8'h01 : rnd[7:0];
    cmd(isa_autoconfig_pkg::IDX_HANDLE, h, "handle");
    $display("test isolation done");
    rd_chk(1'h1, isa_autoconfig_pkg::IDX_HANDLE, 1'h1, h);
    rd_chk(1'h0, isa_autoconfig_pkg::IDX_HANDLE, 1'h1, h);
    rd_chk(1'h1, isa_autoconfig_pkg::IDX_PNP_STATE, 1'h1, 8'h03);
    cmd(isa_autoconfig_pkg::IDX_ACTIVATE, 8'h01, "activate");
    rd_chk(1'h1, isa_autoconfig_pkg::IDX_ACTIVATE, 1'h1, 8'h01);
    cmd(isa_autoconfig_pkg::IDX_CFG_CTRL, 8'h01, "deactivate");
    cmd(isa_autoconfig_pkg::IDX_WAKE, {rnd[15:9] | 7'h01, ~h[0]}, "other wake");
    cmd(isa_autoconfig_pkg::IDX_WAKE, h, "own wake");
    cmd(isa_autoconfig_pkg::IDX_WAKE, 8'h00, "config wake zero");
    cmd(isa_autoconfig_pkg::IDX_WAKE, 8'h00, "sleep wake zero");
    cmd(isa_autoconfig_pkg::IDX_WAKE, h, "wake to config");
    host_u.io_write(isa_autoconfig_pkg::WDATA_PORT ^ 12'h400, 8'h00);
    chk_model("foreign port");
    cmd(isa_autoconfig_pkg::IDX_CFG_CTRL, 8'h02, "to key-wait");
    rd_chk(1'h1, isa_autoconfig_pkg::IDX_HANDLE, 1'h0, 8'h00);
    cmd(isa_autoconfig_pkg::IDX_WAKE, h, "wake without key");
    send_key(-1);
    cmd(isa_autoconfig_pkg::IDX_WAKE, h, "wake after key");
    cmd(isa_autoconfig_pkg::IDX_CFG_CTRL, 8'h04, "clear handle");
    $display("test configuration done");
    @(negedge core_clk);
    srst = 1'h1;
    repeat (2) @(negedge core_clk);
    srst     = 1'h0;
    m_state  = 2'h0;
    m_handle = 8'h00;
    m_act    = 1'h0;
    chk_model("bus reset");
    send_key(-1);
    cmd(isa_autoconfig_pkg::IDX_WAKE, 8'h00, "rewake zero");
    cmd(isa_autoconfig_pkg::IDX_SET_RD, rdp[9:2], "readback again");
    host_u.rival = 1'h1;
    iso_reads(1);
    host_u.rival = 1'h0;
    m_state      = 2'h1;
    chk_model("lost isolation");
    $display("test isolation loss done");
    end_of_test();
  end
endmodule : tb
